/* bench/prcm_line_partner.sv */
// line-side partner: takes framed bytes and echoes them back as received line bytes
`timescale 1ns/10ps
`default_nettype none
module prcm_line_partner (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // modes: stall, silence, drop frame start
    input wire logic i_slow,
    input wire logic i_mute,
    input wire logic i_skew,
    // transmit side
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready,
    // receive side
    output logic o_rx_valid,
    output logic o_rx_sof,
    output logic [7:0] o_rx_data
);
    logic [7:0] idx_r;
    logic ph_r;
    // slow mode takes one byte in two, so a frame overruns its slot
    assign o_tx_ready = !i_slow || ph_r;
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            idx_r <= 8'h00;
            ph_r <= 1'b0;
            o_rx_valid <= 1'b0;
            o_rx_sof <= 1'b0;
            o_rx_data <= 8'h00;
        end
        else
        begin
            ph_r <= !ph_r;
            o_rx_valid <= 1'b0;
            o_rx_sof <= 1'b0;
            // idle line inverts its data byte every cycle rather than holding the last byte
            o_rx_data <= ~o_rx_data;
            if (i_tx_valid && o_tx_ready)
            begin
                idx_r <= (idx_r == 8'h8F) ? 8'h00 : idx_r + 8'h01;
                o_rx_valid <= !i_mute;
                o_rx_sof <= (idx_r == 8'h00) && !i_skew;
                o_rx_data <= i_tx_data;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/prcm_mapper_bench.sv */
// self-checking bench of the core frame mapper
`timescale 1ns/10ps
`default_nettype none
module prcm_mapper_bench;
    import prcm_pkg::*;
    localparam int FC = 200;
    logic i_clk = 1'b0, i_arst_n = 1'b0, i_fail = 1'b0, i_nsp_loop_req = 1'b0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
    logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hF;
    logic [31:0] i_wdata = 32'h0, o_rdata, rd;
    logic i_app_valid = 1'b0, i_line_tx_ready, i_line_rx_valid, i_line_rx_sof;
    logic [7:0] i_app_data = 8'h00, i_line_rx_data, o_app_rx_data, o_line_tx_data;
    logic [PAIRS-1:0] i_pair_active = 2'h0, i_pair_id_ok = 2'h0, o_line_loop;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_app_ready, o_app_rx_valid;
    logic o_line_tx_valid, o_operational, o_signal_loss, o_frame_alignment_loss;
    logic o_remote_active_indication, o_central_active_indication;
    logic [1:0] o_bresp, o_rresp, rr;
    logic [SPARE_W-1:0] o_spare_oh;
    logic slow = 1'b0, mute = 1'b0, skew = 1'b0, feed = 1'b0, chk_tx = 1'b1, chk_rx = 1'b1;
    logic fal_seen = 1'b0, app_hs = 1'b0;
    logic [7:0] expq[$], rxq[$];
    int err_count = 0, samples_checked = 0, tix = 0, nfr = 0, cyc = 0, sof_cyc = 0;
    prcm_mapper #(.FRAME_CYC(FC)) u_dut (
        .i_clk, .i_arst_n, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready, .i_wdata,
        .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
        .i_rready, .o_rdata, .o_rresp, .i_app_valid, .i_app_data, .o_app_ready, .o_app_rx_valid,
        .o_app_rx_data, .o_line_tx_valid, .o_line_tx_data, .i_line_tx_ready, .o_spare_oh,
        .i_line_rx_valid, .i_line_rx_sof, .i_line_rx_data, .i_pair_active, .i_pair_id_ok,
        .i_fail, .i_nsp_loop_req, .o_line_loop, .o_operational, .o_signal_loss,
        .o_frame_alignment_loss, .o_remote_active_indication, .o_central_active_indication
    );
    prcm_line_partner u_far (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_slow(slow), .i_mute(mute), .i_skew(skew),
        .i_tx_valid(o_line_tx_valid), .i_tx_data(o_line_tx_data), .o_tx_ready(i_line_tx_ready),
        .o_rx_valid(i_line_rx_valid), .o_rx_sof(i_line_rx_sof), .o_rx_data(i_line_rx_data)
    );
    initial forever #20 i_clk = ~i_clk;
    //////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (err_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic aw_t, w_t, b_t;
        logic [1:0] br;
        i_awaddr <= a;
        i_wdata <= d;
        i_wstrb <= s;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do
        begin
            // decide on mid-cycle values; reading at the edge races the design
            @(negedge i_clk);
            aw_t = i_awvalid && o_awready;
            w_t = i_wvalid && o_wready;
            b_t = o_bvalid;
            br = o_bresp;
            @(posedge i_clk);
            if (aw_t)
                i_awvalid <= 1'b0;
            if (w_t)
                i_wvalid <= 1'b0;
        end
        while (!b_t);
        chk(br, er);
        i_bready <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_t, r_t;
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do
        begin
            @(negedge i_clk);
            ar_t = i_arvalid && o_arready;
            r_t = o_rvalid;
            d = o_rdata;
            r = o_rresp;
            @(posedge i_clk);
            if (ar_t)
                i_arvalid <= 1'b0;
        end
        while (!r_t);
        i_rready <= 1'b0;
        @(posedge i_clk);
    endtask
    task automatic wait_fr;
        int n;
        n = nfr;
        while (nfr == n)
            @(posedge i_clk);
    endtask
    //////////////////////////////////////////////////////////////////////////////
    // app source holds a byte until taken
    always @(posedge i_clk)
    begin
        if (!i_app_valid || app_hs)
            i_app_valid <= feed;
        if (app_hs)
            i_app_data <= {1'b0, i_app_data[6:0] + 7'h01};
    end
    // tracks frame position by counting accepted bytes; frames are never cut short
    // sampled mid-cycle, so each handshake is seen before the edge that completes it
    always @(negedge i_clk)
    begin
        cyc <= cyc + 1;
        app_hs = i_app_valid && o_app_ready;
        if (o_frame_alignment_loss)
            fal_seen <= 1'b1;
        if (app_hs)
            expq.push_back(i_app_data);
        if (o_line_tx_valid && i_line_tx_ready)
        begin
            tix <= (tix == FRAME_BYTES - 1) ? 0 : tix + 1;
            if (tix == 0)
            begin
                sof_cyc <= cyc;
                nfr <= nfr + 1;
            end
            if (tix % 9 == 0)
                chk(o_line_tx_data, FILL_BYTE);
            else
            begin
                rxq.push_back(o_line_tx_data);
                // fill on an empty fifo is skipped; app bytes never equal it
                if (chk_tx && o_line_tx_data !== FILL_BYTE)
                    chk(o_line_tx_data, expq.pop_front());
            end
        end
        if (o_app_rx_valid && chk_rx)
            chk(o_app_rx_data, rxq.pop_front());
    end
    //////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        chk(o_spare_oh, SPARE_RST);
        axr(ADDR_CTRL, rd, rr);
        chk(rd, {30'h0, CTRL_RST});
        axw(4'hC, 32'h1, 4'hF, RESP_SLVERR);
        axr(4'hC, rd, rr);
        chk({rr, rd}, {RESP_SLVERR, 32'h0});
        axw(ADDR_CTRL, 32'h3, 4'h0, RESP_OK);
        axw(ADDR_STAT, 32'hFFFF_FFFF, 4'hF, RESP_OK);
        axr(ADDR_CTRL, rd, rr);
        chk(rd, 32'h2);
        wait_fr;
        axr(ADDR_STAT, rd, rr);
        chk(rd[4], 1'b1);
    endtask
    task automatic t_frame;
        int t0;
        logic [31:0] f0;
        feed <= 1'b1;
        wait_fr;
        wait_fr;
        t0 = sof_cyc;
        axr(ADDR_FRAMES, f0, rr);
        wait_fr;
        chk(sof_cyc - t0, FC);
        axr(ADDR_FRAMES, rd, rr);
        chk(rd - f0, 32'h1);
    endtask
    task automatic t_status;
        logic [4:0] m;
        i_pair_active <= 2'h3;
        i_pair_id_ok <= 2'h3;
        repeat (8) @(posedge i_clk);
        chk({o_operational, o_central_active_indication}, 2'h3);
        chk(o_remote_active_indication, 1'b0);
        // drop one pair flag, one id flag or raise the failure, in turn
        for (int p = 0; p < 5; p++)
        begin
            m = 5'h1F ^ (5'h01 << p);
            i_pair_active <= m[1:0];
            i_pair_id_ok <= m[3:2];
            i_fail <= !m[4];
            repeat (8) @(posedge i_clk);
            chk({o_operational, o_central_active_indication}, 2'h0);
            i_pair_active <= 2'h3;
            i_pair_id_ok <= 2'h3;
            i_fail <= 1'b0;
            repeat (8) @(posedge i_clk);
            chk(o_operational, 1'b1);
        end
    endtask
    task automatic t_loss;
        chk_rx <= 1'b0;
        mute <= 1'b1;
        repeat (FC + 8) @(posedge i_clk);
        chk({o_signal_loss, o_operational}, 2'h2);
        mute <= 1'b0;
        wait_fr;
        wait_fr;
        chk({o_signal_loss, o_frame_alignment_loss, o_operational}, 3'h1);
        fal_seen <= 1'b0;
        skew <= 1'b1;
        wait_fr;
        wait_fr;
        chk(fal_seen, 1'b1);
        skew <= 1'b0;
    endtask
    task automatic t_loop;
        logic [31:0] f0;
        chk_tx <= 1'b0;
        feed <= 1'b0;
        slow <= 1'b1;
        i_nsp_loop_req <= 1'b1;
        repeat (8) @(posedge i_clk);
        chk(o_line_loop, 2'h0);
        axw(ADDR_CTRL, 32'h3, 4'h1, RESP_OK);
        repeat (8) @(posedge i_clk);
        chk({o_line_loop, o_app_ready}, 3'h6);
        axr(ADDR_STAT, rd, rr);
        chk(rd[3], 1'b1);
        wait_fr;
        wait_fr;
        axw(ADDR_CTRL, 32'h2, 4'h1, RESP_OK);
        repeat (8) @(posedge i_clk);
        chk(o_line_loop, 2'h0);
        chk(o_spare_oh, SPARE_RST);
        // transmit disabled: a slow frame in flight ends, then no new frame
        axw(ADDR_CTRL, 32'h0, 4'h1, RESP_OK);
        repeat (320) @(posedge i_clk);
        axr(ADDR_FRAMES, f0, rr);
        repeat (2 * FC) @(posedge i_clk);
        axr(ADDR_FRAMES, rd, rr);
        chk(rd, f0);
    endtask
    //////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge i_clk);
        i_arst_n <= 1'b1;
        @(posedge i_clk);
        t_regs;
        t_frame;
        t_status;
        t_loss;
        t_loop;
        wrap_up;
    end
    // whole run takes some 3500 cycles
    initial
    begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        wrap_up;
    end
endmodule
`default_nettype wire

/* verilog/prcm_fifo.sv */
// byte fifo with registered head word
`timescale 1ns/10ps
`default_nettype none
module prcm_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // fill side
    input wire logic i_valid,
    input wire logic [W-1:0] i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [W-1:0] dout;
    } prcm_fifo_st_t;

    prcm_fifo_st_t r;
    prcm_fifo_st_t n;
    logic push;
    logic pop;

    assign o_ready = (r.cnt != (AW+1)'(D));
    assign o_valid = r.ov;
    assign o_data = r.dout;

    always_comb
    begin
        n = r;
        push = i_valid && o_ready;
        pop = (r.cnt != '0) && (!r.ov || i_ready);
        if (r.ov && i_ready)
        begin
            n.ov = 1'b0;
        end
        // head register refills in the cycle it drains, no bubble
        if (pop)
        begin
            n.dout = r.mem[r.rp];
            n.ov = 1'b1;
            n.rp = r.rp + 1'b1;
        end
        if (push)
        begin
            n.mem[r.wp] = i_data;
            n.wp = r.wp + 1'b1;
        end
        if (push && !pop)
        begin
            n.cnt = r.cnt + 1'b1;
        end
        else if (pop && !push)
        begin
            n.cnt = r.cnt - 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end
endmodule
`default_nettype wire

/* verilog/prcm_mapper.sv */
// core frame mapper: framing, deframing, section state, loopback, axi4-lite regs
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Contract
// - 144-byte core frame every 500 us
// - 128 payload bytes, 16 all-ones stuffing bytes
// - no alignment of time slot 0
// - transparent; app framing loss never resyncs
// - spare overhead bits m9..m48 sent as ones
// - operational: all pairs active, ids ok
// - any pair failing means non-operational
// - loopback 1 loops all line transceivers
// - loopback 1 managed by maintenance control
// - core raises loss and active indications
// - application clock 2048 kHz, 50 ppm
module prcm_mapper #(
    parameter int FRAME_CYC = prcm_pkg::FRAME_CYC_DEF
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // axi4-lite slave
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [3:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [3:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    // application stream in
    input wire logic i_app_valid,
    input wire logic [7:0] i_app_data,
    output logic o_app_ready,
    // application stream out
    output logic o_app_rx_valid,
    output logic [7:0] o_app_rx_data,
    // line transmit
    output logic o_line_tx_valid,
    output logic [7:0] o_line_tx_data,
    input wire logic i_line_tx_ready,
    output logic [prcm_pkg::SPARE_W-1:0] o_spare_oh,
    // line receive
    input wire logic i_line_rx_valid,
    input wire logic i_line_rx_sof,
    input wire logic [7:0] i_line_rx_data,
    // transceiver pair status pins
    input wire logic [prcm_pkg::PAIRS-1:0] i_pair_active,
    input wire logic [prcm_pkg::PAIRS-1:0] i_pair_id_ok,
    input wire logic i_fail,
    input wire logic i_nsp_loop_req,
    // indications
    output logic [prcm_pkg::PAIRS-1:0] o_line_loop,
    output logic o_operational,
    output logic o_signal_loss,
    output logic o_frame_alignment_loss,
    output logic o_remote_active_indication,
    output logic o_central_active_indication
);
    import prcm_pkg::*;

    typedef struct packed {
        logic [PAIRS-1:0] act_m;
        logic [PAIRS-1:0] act_s;
        logic [PAIRS-1:0] id_m;
        logic [PAIRS-1:0] id_s;
        logic fail_m;
        logic fail_s;
        logic lb_m;
        logic lb_s;
        logic [1:0] ctrl;
        logic aw_ok;
        logic [3:0] awaddr;
        logic w_ok;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        prcm_txst_t txst;
        logic [15:0] tick;
        logic [7:0] tx_idx;
        logic tx_valid;
        logic [7:0] tx_data;
        logic [7:0] tx_pos;
        logic [7:0] rx_idx;
        logic rx_valid;
        logic [7:0] rx_data;
        logic [15:0] quiet;
        prcm_stat_t stat;
        logic [31:0] frames;
        logic [SPARE_W-1:0] spare;
    } prcm_st_t;

    prcm_st_t r;
    prcm_st_t n;
    logic f_in_valid;
    logic [7:0] f_in_data;
    logic f_in_ready;
    logic f_valid;
    logic [7:0] f_data;
    logic f_ready;
    logic load;
    logic [7:0] rx_pos;
    logic lb_now;
    logic oper_now;

    // payload per frame equals 2048 kbit/s over 500 us
    localparam int PAYLOAD_CHK = FRAME_BYTES - STUFF_BYTES;

    //////////////////////////////////////////////////////////////////////////
    // payload buffer; loopback feeds received payload back toward the line
    assign lb_now = r.ctrl[CTRL_LB_BIT] && r.lb_s;
    assign f_in_valid = r.stat.lb ? r.rx_valid : i_app_valid;
    assign f_in_data = r.stat.lb ? r.rx_data : i_app_data;
    assign o_app_ready = !r.stat.lb && f_in_ready;
    assign load = (r.txst == TX_SEND) && (!r.tx_valid || i_line_tx_ready);
    assign f_ready = load && !STUFF_MAP[r.tx_idx];

    prcm_fifo #(
        .W(DW),
        .D(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_valid(f_in_valid),
        .i_data(f_in_data),
        .o_ready(f_in_ready),
        .o_valid(f_valid),
        .o_data(f_data),
        .i_ready(f_ready)
    );

    //////////////////////////////////////////////////////////////////////////
    // outputs
    assign o_awready = !r.aw_ok && !r.bvalid;
    assign o_wready = !r.w_ok && !r.bvalid;
    assign o_bvalid = r.bvalid;
    assign o_bresp = r.bresp;
    assign o_arready = !r.rvalid;
    assign o_rvalid = r.rvalid;
    assign o_rdata = r.rdata;
    assign o_rresp = r.rresp;
    assign o_app_rx_valid = r.rx_valid;
    assign o_app_rx_data = r.rx_data;
    assign o_line_tx_valid = r.tx_valid;
    assign o_line_tx_data = r.tx_data;
    assign o_spare_oh = r.spare;
    assign o_line_loop = {PAIRS{r.stat.lb}};
    assign o_operational = r.stat.oper;
    assign o_signal_loss = r.stat.signal_loss;
    assign o_frame_alignment_loss = r.stat.fal;
    assign o_remote_active_indication = !IS_LTU && r.stat.oper;
    assign o_central_active_indication = IS_LTU && r.stat.oper;

    assign oper_now = (&r.act_s) && (&r.id_s) && !r.fail_s
        && !r.stat.signal_loss && !r.stat.fal;
    assign rx_pos = i_line_rx_sof ? 8'h00 : r.rx_idx;

    //////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        n = r;
        // pins pass two flops before use
        n.act_m = i_pair_active;
        n.act_s = r.act_m;
        n.id_m = i_pair_id_ok;
        n.id_s = r.id_m;
        n.fail_m = i_fail;
        n.fail_s = r.fail_m;
        n.lb_m = i_nsp_loop_req;
        n.lb_s = r.lb_m;
        n.stat.oper = oper_now;
        n.stat.lb = lb_now;
        n.spare = SPARE_RST;

        // axi write: address and data taken in either order
        if (i_awvalid && o_awready)
        begin
            n.aw_ok = 1'b1;
            n.awaddr = i_awaddr;
        end
        if (i_wvalid && o_wready)
        begin
            n.w_ok = 1'b1;
            n.wdata = i_wdata;
            n.wstrb = i_wstrb;
        end
        if (r.bvalid && i_bready)
        begin
            n.bvalid = 1'b0;
        end
        if (r.aw_ok && r.w_ok && !r.bvalid)
        begin
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OK;
            unique case (r.awaddr)
                ADDR_CTRL:
                begin
                    if (r.wstrb[0])
                    begin
                        n.ctrl = r.wdata[1:0];
                    end
                end
                ADDR_STAT, ADDR_FRAMES:
                begin
                    n.bresp = RESP_OK;
                end
                default:
                begin
                    n.bresp = RESP_SLVERR;
                end
            endcase
        end

        // axi read
        if (r.rvalid && i_rready)
        begin
            n.rvalid = 1'b0;
        end
        if (i_arvalid && o_arready)
        begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OK;
            n.rdata = '0;
            unique case (i_araddr)
                ADDR_CTRL: n.rdata = {30'h0, r.ctrl};
                ADDR_STAT: n.rdata = {27'h0, r.stat};
                ADDR_FRAMES: n.rdata = r.frames;
                default: n.rresp = RESP_SLVERR;
            endcase
        end

        // 500 us frame pacing
        if (r.tick == '0)
        begin
            n.tick = 16'(FRAME_CYC - 1);
        end
        else
        begin
            n.tick = r.tick - 1'b1;
        end

        // transmit framer; payload not aligned to any app boundary
        if (r.tx_valid && i_line_tx_ready)
        begin
            n.tx_valid = 1'b0;
        end
        unique case (r.txst)
            TX_WAIT:
            begin
                if (r.tick == '0 && r.ctrl[CTRL_TXEN_BIT])
                begin
                    n.txst = TX_SEND;
                    n.tx_idx = '0;
                end
            end
            TX_SEND:
            begin
                if (load)
                begin
                    n.tx_valid = 1'b1;
                    n.tx_pos = r.tx_idx;
                    if (STUFF_MAP[r.tx_idx])
                    begin
                        n.tx_data = FILL_BYTE;
                    end
                    else if (f_valid)
                    begin
                        n.tx_data = f_data;
                    end
                    else
                    begin
                        // underrun sends ones rather than stalling the line
                        n.tx_data = FILL_BYTE;
                        n.stat.underrun = 1'b1;
                    end
                    n.tx_idx = r.tx_idx + 1'b1;
                    if (r.tx_idx == LAST_IDX)
                    begin
                        n.txst = TX_WAIT;
                        n.frames = r.frames + 1'b1;
                    end
                end
            end
        endcase

        // receive deframer; app content is never inspected here
        n.rx_valid = 1'b0;
        if (i_line_rx_valid)
        begin
            n.quiet = '0;
            n.stat.fal = i_line_rx_sof != (r.rx_idx == 8'h00);
            n.rx_idx = (rx_pos == LAST_IDX) ? 8'h00 : rx_pos + 1'b1;
            n.rx_valid = !STUFF_MAP[rx_pos];
            n.rx_data = i_line_rx_data;
        end
        else if (r.quiet != 16'hFFFF)
        begin
            n.quiet = r.quiet + 1'b1;
        end
        n.stat.signal_loss = (r.quiet >= 16'(FRAME_CYC));
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            r <= '0;
            r.ctrl <= CTRL_RST;
            r.spare <= SPARE_RST;
        end
        else
        begin
            r <= n;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);

    a_stuff_fill: assert property (o_line_tx_valid && STUFF_MAP[r.tx_pos]
        |-> o_line_tx_data == FILL_BYTE) else $error("stuff byte not ones");
    a_frame_len: assert property (r.txst == TX_SEND |-> r.tx_idx <= LAST_IDX)
        else $error("frame longer than 144");
    a_frame_pace: assert property ($rose(r.txst == TX_SEND) |-> $past(r.tick) == '0)
        else $error("frame started off tick");
    a_spare_ones: assert property (1'b1 ##1 o_spare_oh == SPARE_RST)
        else $error("spare bits not ones");
    a_oper_set: assert property ((&r.act_s) && (&r.id_s) && !r.fail_s
        && !r.stat.signal_loss && !r.stat.fal |=> o_operational) else $error("oper missed");
    a_oper_clr: assert property (!(&r.act_s) || !(&r.id_s)
        |=> !o_operational) else $error("oper despite pair fault");
    a_loop_on: assert property (r.ctrl[CTRL_LB_BIT] && r.lb_s
        |=> (&o_line_loop) && !o_app_ready) else $error("loop not active");
    a_loop_off: assert property (!r.ctrl[CTRL_LB_BIT] |=> o_line_loop == '0)
        else $error("loop without maintenance");
    a_rx_drop: assert property (i_line_rx_valid && !i_line_rx_sof && STUFF_MAP[r.rx_idx]
        |=> !o_app_rx_valid) else $error("stuff byte passed to app");
    a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("bvalid dropped");

    c_frame_done: cover property (r.txst == TX_SEND ##1 r.txst == TX_WAIT);
    c_loop: cover property ($rose(o_line_loop[0]));
    c_los: cover property ($rose(o_signal_loss));
    c_oper: cover property ($rose(o_operational));
endmodule
`default_nettype wire

/* verilog/prcm_pkg.sv */
// package: constants and types of the primary-rate core frame mapper
package prcm_pkg;
    // stream and frame geometry
    localparam int DW = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int FRAME_BYTES = 144;
    localparam int STUFF_BYTES = 16;
    localparam int PAIRS = 2;
    // timing
    localparam int CLK_HZ = 25_000_000;
    localparam int FRAME_US = 500;
    localparam int APP_KHZ = 2048;
    localparam int APP_PPM = 50;
    localparam int FRAME_CYC_DEF = FRAME_US * (CLK_HZ / 1_000_000);
    localparam int PAYLOAD_BYTES = APP_KHZ * FRAME_US / 8000;
    // stuffing byte positions, one bit per byte slot
    localparam logic [FRAME_BYTES-1:0] STUFF_MAP = {STUFF_BYTES{9'h001}};
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam logic [7:0] LAST_IDX = 8'h8F;
    // spare overhead bits m9..m48
    localparam int SPARE_FIRST = 9;
    localparam int SPARE_LAST = 48;
    localparam int SPARE_W = SPARE_LAST - SPARE_FIRST + 1;
    localparam logic [SPARE_W-1:0] SPARE_RST = {SPARE_W{1'b1}};
    // register map
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_FRAMES = 4'h8;
    localparam int CTRL_LB_BIT = 0;
    localparam int CTRL_TXEN_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h2;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // unit role: line termination end when set
    localparam logic IS_LTU = 1'b1;

    typedef struct packed {
        logic underrun;
        logic lb;
        logic fal;
        logic signal_loss;
        logic oper;
    } prcm_stat_t;

    typedef enum logic {TX_WAIT, TX_SEND} prcm_txst_t;
endpackage
